//--- hdl/qsuf_params.svh
// Offsets, field positions, reset values and fixed bits of the
// queue split and unknown-destination forward control registers.
// Assumes an 8-bit register port with byte addresses.
`ifndef QSUF_PARAMS_SVH
`define QSUF_PARAMS_SVH

// ============================================================
// Register offsets
`define QSUF_ADDR_SPLIT 8'h82
`define QSUF_ADDR_UC 8'h83
`define QSUF_ADDR_MC 8'h84

// ============================================================
// Field positions
`define QSUF_SPLIT_MSB 7
`define QSUF_SPLIT_LSB 6
`define QSUF_EN_BIT 5
`define QSUF_MAP_MSB 4
`define QSUF_MAP_LSB 0

// ============================================================
// Reset values and fixed read-only bits
`define QSUF_SPLIT_RST 2'h2
`define QSUF_EN_RST 1'h0
`define QSUF_MAP_RST 5'h00
`define QSUF_RSV_SPLIT 6'h08
`define QSUF_RSV_UC 2'h2
`define QSUF_RSV_MC 2'h1
`define QSUF_RD_ZERO 8'h00

// Bit 3 of a forward map is reserved and never names a port
`define QSUF_PORT_MASK 5'h17

`endif

//--- hdl/qsuf_pkg.sv
// Types shared by the queue split and forward control block.
// Assumes qsuf_params.svh supplies the numeric constants.
package qsuf_pkg;

    // Split field codes; 2'h1 is not a supported setting
    typedef enum logic [1:0]
    {
        SPLIT_ONLY3_HI = 2'h0,
        SPLIT_UNSUPP = 2'h1,
        SPLIT_23_HI = 2'h2,
        SPLIT_123_HI = 2'h3
    } qsuf_split_t;

    typedef logic [4:0] qsuf_pmap_t;

endpackage

//--- hdl/qsuf_fwd_if.sv
// Carrier between the control top and one forward selector.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
interface qsuf_fwd_if;
    import qsuf_pkg::*;
    logic req;
    logic en;
    qsuf_pmap_t map;
    logic vld;
    qsuf_pmap_t ports;
    modport ctrl (output req, output en, output map, input vld, input ports);
    modport sel (input req, input en, input map, output vld, output ports);
endinterface

//--- hdl/qsuf_fwd_sel.sv
// Forward port selector for one class of unknown-destination frame.
// Assumes a synchronous request pulse and a reset already synchronised.
`timescale 1ns/1ps
`include "qsuf_params.svh"
module qsuf_fwd_sel
    import qsuf_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    qsuf_fwd_if.sel fwd
);

    logic vld_q;
    qsuf_pmap_t ports_q;

    // ============================================================
    // Answer one cycle after the request
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            vld_q <= 1'b0;
        else
            vld_q <= fwd.req;
    end

    // Disabled forwarding or an all-zero map drops the frame
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ports_q <= `QSUF_MAP_RST;
        else if (fwd.req)
            ports_q <= fwd.en ? (fwd.map & `QSUF_PORT_MASK) : `QSUF_MAP_RST;
    end

    assign fwd.vld = vld_q;
    assign fwd.ports = ports_q;

endmodule

//--- hdl/qsuf_top.sv
// Queue split and unknown-destination forward control registers.
// Assumes a same-clock register master and same-clock frame logic.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`include "qsuf_params.svh"

// How it works
// - In two-queue mode the split field sends each priority to low or high queue.
// - Split 00: priorities 0,1,2 low, 3 high.
// - Split 10, the reset value: priorities 0,1 low, 2,3 high.
// - Split 11: only priority 0 low, others high.
// - Unknown unicast forward enable uses the unicast port map; resets to 0.
// - Unicast port map is a per-port mask; 00000 drops the frame.
// - Map bit 3 is reserved and never selects a port.
// - Unknown non-IP multicast forward enable uses the multicast map; resets to 0.
// - Multicast map has the unicast encoding, bit 3 reserved, resets 00000.
module qsuf_top
    import qsuf_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic TWO_QUEUE_I,
    input wire logic PRIO_VLD_I,
    input wire logic [1:0] PRIO_I,
    output logic QUEUE_VLD_O,
    output logic [1:0] QUEUE_O,
    input wire logic FRAME_VLD_I,
    input wire logic UNK_UC_I,
    input wire logic UNK_MC_I,
    output logic UC_FWD_VLD_O,
    output logic [4:0] UC_PORTS_O,
    output logic MC_FWD_VLD_O,
    output logic [4:0] MC_PORTS_O
);

    // ============================================================
    // Reset release
    logic rst_s1_q;
    logic rst_n;

    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // ============================================================
    // Registers
    qsuf_split_t split_q;
    logic uc_en_q;
    qsuf_pmap_t uc_map_q;
    logic mc_en_q;
    qsuf_pmap_t mc_map_q;
    logic [7:0] rdata_q;
    logic [7:0] rd_mux;

    // Only the writable fields are stored; reserved bits are constants
    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            split_q <= qsuf_split_t'(`QSUF_SPLIT_RST);
        else if (WR_I && ADDR_I == `QSUF_ADDR_SPLIT)
            split_q <= qsuf_split_t'(WDATA_I[`QSUF_SPLIT_MSB:`QSUF_SPLIT_LSB]);
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            uc_en_q <= `QSUF_EN_RST;
            uc_map_q <= `QSUF_MAP_RST;
        end
        else if (WR_I && ADDR_I == `QSUF_ADDR_UC)
        begin
            uc_en_q <= WDATA_I[`QSUF_EN_BIT];
            uc_map_q <= WDATA_I[`QSUF_MAP_MSB:`QSUF_MAP_LSB];
        end
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mc_en_q <= `QSUF_EN_RST;
            mc_map_q <= `QSUF_MAP_RST;
        end
        else if (WR_I && ADDR_I == `QSUF_ADDR_MC)
        begin
            mc_en_q <= WDATA_I[`QSUF_EN_BIT];
            mc_map_q <= WDATA_I[`QSUF_MAP_MSB:`QSUF_MAP_LSB];
        end
    end

    // ============================================================
    // Read path: data valid only in the cycle after the strobe
    always_comb
    begin
        case (ADDR_I)
            `QSUF_ADDR_SPLIT: rd_mux = {split_q, `QSUF_RSV_SPLIT};
            `QSUF_ADDR_UC: rd_mux = {`QSUF_RSV_UC, uc_en_q, uc_map_q};
            `QSUF_ADDR_MC: rd_mux = {`QSUF_RSV_MC, mc_en_q, mc_map_q};
            default: rd_mux = `QSUF_RD_ZERO;
        endcase
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= `QSUF_RD_ZERO;
        else if (RD_I)
            rdata_q <= rd_mux;
        else
            rdata_q <= `QSUF_RD_ZERO;
    end

    assign RDATA_O = rdata_q;

    // ============================================================
    // Queue selection
    logic queue_vld_q;
    logic [1:0] queue_q;
    logic split_hi;

    // Priority 0 is always low and 3 always high; 1 and 2 follow the split bits
    always_comb
    begin
        case (PRIO_I)
            2'h0: split_hi = 1'b0;
            2'h1: split_hi = split_q[0];
            2'h2: split_hi = split_q[1];
            default: split_hi = 1'b1;
        endcase
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            queue_vld_q <= 1'b0;
        else
            queue_vld_q <= PRIO_VLD_I;
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
            queue_q <= 2'h0;
        else if (PRIO_VLD_I && TWO_QUEUE_I)
            queue_q <= {1'b0, split_hi};
        else if (PRIO_VLD_I)
            queue_q <= PRIO_I;
    end

    assign QUEUE_VLD_O = queue_vld_q;
    assign QUEUE_O = queue_q;

    // ============================================================
    // Unknown-destination forwarding
    qsuf_fwd_if uc_if ();
    qsuf_fwd_if mc_if ();

    assign uc_if.req = FRAME_VLD_I && UNK_UC_I;
    assign uc_if.en = uc_en_q;
    assign uc_if.map = uc_map_q;
    assign mc_if.req = FRAME_VLD_I && UNK_MC_I;
    assign mc_if.en = mc_en_q;
    assign mc_if.map = mc_map_q;

    qsuf_fwd_sel u_uc_sel (.clk_i(CLK_I), .rst_n_i(rst_n), .fwd(uc_if.sel));
    qsuf_fwd_sel u_mc_sel (.clk_i(CLK_I), .rst_n_i(rst_n), .fwd(mc_if.sel));

    assign UC_FWD_VLD_O = uc_if.vld;
    assign UC_PORTS_O = uc_if.ports;
    assign MC_FWD_VLD_O = mc_if.vld;
    assign MC_PORTS_O = mc_if.ports;

    // ============================================================
    // Checks
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!rst_n);

    a_split_two_queue: assert property (
        PRIO_VLD_I && TWO_QUEUE_I |=> QUEUE_VLD_O && QUEUE_O[1] == 1'b0
            && (QUEUE_O[0] == ($past(PRIO_I) == 2'h3) || $past(PRIO_I) == 2'h1
            || $past(PRIO_I) == 2'h2))
        else $error("two-queue result out of range");
    a_split_zero_map: assert property (
        PRIO_VLD_I && TWO_QUEUE_I && split_q == SPLIT_ONLY3_HI
            |=> QUEUE_O[0] == ($past(PRIO_I) == 2'h3))
        else $error("split 00 queue wrong");
    a_split_two_map: assert property (
        PRIO_VLD_I && TWO_QUEUE_I && split_q == SPLIT_23_HI
            |=> QUEUE_O[0] == ($past(PRIO_I) >= 2'h2))
        else $error("split 10 queue wrong");
    a_split_three_map: assert property (
        PRIO_VLD_I && TWO_QUEUE_I && split_q == SPLIT_123_HI
            |=> QUEUE_O[0] == ($past(PRIO_I) != 2'h0))
        else $error("split 11 queue wrong");
    a_uc_forward_map: assert property (
        FRAME_VLD_I && UNK_UC_I |=> UC_FWD_VLD_O
            && UC_PORTS_O == ($past(uc_en_q) ? ($past(uc_map_q) & 5'h17) : 5'h00))
        else $error("unicast forward ports wrong");
    a_reserved_port_bit: assert property (
        !UC_PORTS_O[3] && !MC_PORTS_O[3])
        else $error("reserved port bit forwarded");
    a_mc_forward_map: assert property (
        FRAME_VLD_I && UNK_MC_I |=> MC_FWD_VLD_O
            && MC_PORTS_O == ($past(mc_en_q) ? ($past(mc_map_q) & 5'h17) : 5'h00))
        else $error("multicast forward ports wrong");
    a_reserved_read_back: assert property (
        RD_I && (ADDR_I == 8'h82 || ADDR_I == 8'h83 || ADDR_I == 8'h84)
            |=> (RDATA_O[5:0] == 6'h08 || $past(ADDR_I) != 8'h82)
            && (RDATA_O[7:6] == 2'h2 || $past(ADDR_I) != 8'h83)
            && (RDATA_O[7:6] == 2'h1 || $past(ADDR_I) != 8'h84))
        else $error("reserved bits read wrong");
    a_prio_pass_through: assert property (
        PRIO_VLD_I && !TWO_QUEUE_I |=> QUEUE_VLD_O && QUEUE_O == $past(PRIO_I))
        else $error("priority not passed through");

    c_two_queue_high: cover property (PRIO_VLD_I && TWO_QUEUE_I ##1 QUEUE_O[0]);
    c_uc_forwarded: cover property (uc_en_q && uc_if.req ##1 UC_PORTS_O != 5'h00);
    c_mc_dropped: cover property (mc_if.req && !mc_en_q);
    c_write_then_read: cover property (WR_I && ADDR_I == 8'h82 ##1 RD_I && ADDR_I == 8'h82);

endmodule

//--- test/qsuf_top_tb.sv
// Self-checking bench for the queue split and forward control block.
// Assumes the design files under hdl/ and a 100 MHz core clock.
`timescale 1ns/1ps
`include "qsuf_params.svh"
module qsuf_top_tb
    import qsuf_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n, wr, rd, two_q, prio_vld, frame_vld, unk_uc, unk_mc;
    logic [7:0] addr, wdata, rdata, v, d;
    logic [1:0] prio, queue, split_m;
    logic queue_vld, uc_vld, mc_vld;
    logic [4:0] uc_ports, mc_ports;
    logic [7:0] uc_m, mc_m;
    logic [31:0] seed;
    int mismatches, tests_run, cycles;

    qsuf_top qsuf_top_i (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TWO_QUEUE_I(two_q), .PRIO_VLD_I(prio_vld),
        .PRIO_I(prio), .QUEUE_VLD_O(queue_vld), .QUEUE_O(queue), .FRAME_VLD_I(frame_vld),
        .UNK_UC_I(unk_uc), .UNK_MC_I(unk_mc), .UC_FWD_VLD_O(uc_vld), .UC_PORTS_O(uc_ports),
        .MC_FWD_VLD_O(mc_vld), .MC_PORTS_O(mc_ports));

    always #5 clk = ~clk;

    // ============================================================
    // Expectations
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        case (a)
            8'h82: return {split_m, 6'h08};
            8'h83: return uc_m;
            8'h84: return mc_m;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [1:0] exp_q(input logic [1:0] p, input logic t);
        if (!t)
            return p;
        case (split_m)
            2'h0: return {1'b0, p == 2'h3};
            2'h3: return {1'b0, p != 2'h0};
            default: return {1'b0, p[1]};
        endcase
    endfunction

    function automatic logic [4:0] exp_ports(input logic [7:0] r);
        return r[5] ? (r[4:0] & 5'h17) : 5'h00;
    endfunction

    // ============================================================
    // Compare tasks
    task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t read got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_q(input logic [2:0] got, input logic [2:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t queue got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_fwd(input logic [5:0] got, input logic [5:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t forward got %h exp %h", $time, got, exp);
        end
    endtask

    // ============================================================
    // Bus and traffic tasks
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] dat);
        @(posedge clk);
        addr <= a;
        wdata <= dat;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a == 8'h82)
            split_m = dat[7:6];
        if (a == 8'h83)
            uc_m = {2'h2, dat[5:0]};
        if (a == 8'h84)
            mc_m = {2'h1, dat[5:0]};
    endtask

    task automatic reg_rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk_rd(rdata, exp_rd(a));
    endtask

    task automatic q_run(input logic [1:0] p, input logic t);
        @(posedge clk);
        prio_vld <= 1'b1;
        prio <= p;
        two_q <= t;
        @(posedge clk);
        prio_vld <= 1'b0;
        #1;
        chk_q({queue_vld, queue}, {1'b1, exp_q(p, t)});
    endtask

    task automatic fw_run(input logic f, input logic u, input logic m);
        @(posedge clk);
        frame_vld <= f;
        unk_uc <= u;
        unk_mc <= m;
        @(posedge clk);
        frame_vld <= 1'b0;
        #1;
        chk_fwd({uc_vld, (f & u) ? uc_ports : 5'h00}, {f & u, (f & u) ? exp_ports(uc_m) : 5'h00});
        chk_fwd({mc_vld, (f & m) ? mc_ports : 5'h00}, {f & m, (f & m) ? exp_ports(mc_m) : 5'h00});
    endtask

    task automatic tally_and_finish();
        if (mismatches == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    // ============================================================
    // Main sequence
    initial
    begin
        {rst_n, wr, rd, two_q, prio_vld, frame_vld, unk_uc, unk_mc} = 8'h00;
        {addr, wdata, prio} = 18'h00000;
        split_m = 2'h2;
        uc_m = 8'h80;
        mc_m = 8'h40;
        seed = 32'h5796DB8D;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int a = 8'h80; a < 8'h88; a++)
            reg_rd(a[7:0]);
        for (int p = 0; p < 4; p++)
            q_run(p[1:0], 1'b1);
        fw_run(1'b1, 1'b1, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            reg_wr(8'h82, {i == 0 ? 2'h0 : (i == 1 ? 2'h3 : 2'h2), 6'h37});
            reg_rd(8'h82);
            for (int p = 0; p < 8; p++)
                q_run(p[1:0], p < 4);
        end
        for (int i = 0; i < 7; i++)
        begin
            d = i == 0 ? 8'h3F : i == 1 ? 8'h20 : i == 2 ? 8'h1F : i == 3 ? 8'h21 :
                i == 4 ? 8'h23 : i == 5 ? 8'h27 : 8'hFF;
            reg_wr(8'h83, d);
            reg_wr(8'h84, ~d);
            fw_run(1'b1, 1'b1, 1'b1);
        end
        for (int n = 0; n < 300; n++)
        begin
            seed = lfsr(seed);
            v = 8'h80 | {5'h00, seed[2:0]};
            d = seed[15:8];
            if (v == 8'h82 && d[7:6] == 2'h1)
                d[7:6] = 2'h3;
            reg_wr(v, d);
            reg_rd(v);
            q_run(seed[17:16], seed[18]);
            fw_run(seed[19] | seed[22], seed[20], seed[21]);
        end
        tally_and_finish();
    end
endmodule
